// file: rtl/rtc_counter_map.vh
`ifndef RTC_COUNTER_MAP_VH
`define RTC_COUNTER_MAP_VH

// Register offsets
`define REG_SEC0 8'h00
`define REG_SEC3 8'h03
`define REG_GUARD0 8'h04
`define REG_GUARD2 8'h06
`define REG_CONTROL 8'h07
`define REG_STATUS 8'h08
`define PTR_FIRST 8'h00

// Control fields
`define CTL_OSC_STOP 7
`define CTL_GUARD_EN 6
`define CTL_MODE_SEL 5
`define CTL_OUT_FUNC 3
`define CTL_RATE_HI 2
`define CTL_RATE_LO 1
`define CTL_IRQ_EN 0
`define CTL_RESET 8'h06
`define CTL_WMASK 8'hEF

// Status fields
`define STS_OSC_HALT 7
`define STS_REACHED 0

// Rate select codes
`define RATE_1HZ 2'h0
`define RATE_4096HZ 2'h1
`define RATE_8192HZ 2'h2
`define RATE_32768HZ 2'h3

// Timebase
`define XTAL_HZ 32768
`define PRE_WIDTH 3
`define PRE_WRAP 3'h7
`define CHAIN_WIDTH 12
`define CHAIN_WRAP 12'hFFF
`define PULSE_MS 250
`define PULSE_TICKS ((`PULSE_MS * `XTAL_HZ) / 1000)
`define PULSE_WIDTH 14

// Serial bus
`define BIT_COUNT 4'h8
`define READ_BIT 0

`endif

// file: rtl/seconds_counter_rtc.v
`include "rtc_counter_map.vh"
`default_nettype none

// Contract
// - 32-bit seconds up counter, host loaded
// - 24-bit counter as watchdog or alarm
// - Strobe rising edge restarts guard counter
// - Static strobe level never restarts counter
// - Output pin only pulls low or releases
// - All timing from 32.768 kHz timebase
// - Pointer wraps from last register to first
// - Time captured on START, STOP, wrap
// - Time reads return the captured copy
// - Seconds 00-03, guard 04-06, control 07, status 08
// - Guard bytes ascend from 04 to 06
// - Most registers undefined until host writes
// - Guard write loads counter and seed
// - Mode 0 per second reload, 1 fast stop
// - Rate bits pick square-wave frequency
// - Flag write-zero clear, 250 ms pulse
module seconds_counter_rtc #(
  parameter [6:0] SLAVE_ADDR = 7'h5A // Arbitrary value
) (
  input wire clock,
  input wire nrst,
  input wire xtalIn,
  input wire sclIn,
  input wire sdaIn,
  output reg sdaOut,
  output reg sdaOe,
  input wire guard_strobe_in,
  output reg wave_or_irq_out,
  output reg waveOe
);
  localparam [6:0] S_IDLE = 7'h01;
  localparam [6:0] S_ADDR = 7'h02;
  localparam [6:0] S_ACK = 7'h04;
  localparam [6:0] S_PTR = 7'h08;
  localparam [6:0] S_WDATA = 7'h10;
  localparam [6:0] S_RDATA = 7'h20;
  localparam [6:0] S_RACK = 7'h40;

  reg rstMeta, rstn;
  reg [1:0] xtalSync, sclSync, sdaSync, strobeSync;
  reg xtalPrev, sclPrev, sdaPrev, strobePrev;
  reg [6:0] state, afterAck;
  reg [3:0] bitCnt;
  reg [7:0] shiftIn, shiftOut, ptr;
  reg [7:0] readNow;
  reg [31:0] seconds_count, secShadow;
  reg [23:0] guardCount, guardSeed;
  reg guardRun, pulseActive, nackSeen;
  reg [`PULSE_WIDTH-1:0] pulseCnt;
  reg [7:0] control;
  reg osc_halted_flag, count_reached_flag;
  reg secClear, guardClear;
  wire secTick, guardSlowTick, guardFastTick, waveLevel;

  wire sclHi = sclSync[1];
  wire sdaHi = sdaSync[1];
  wire sclRise = sclHi && !sclPrev;
  wire sclFall = !sclHi && sclPrev;
  wire busStart = sclHi && sclPrev && sdaPrev && !sdaHi;
  wire busStop = sclHi && sclPrev && !sdaPrev && sdaHi;
  wire osc_stop_ctl = control[`CTL_OSC_STOP];
  wire guard_counter_enable = control[`CTL_GUARD_EN];
  wire counter_mode_select = control[`CTL_MODE_SEL];
  wire output_function_select = control[`CTL_OUT_FUNC];
  wire alarm_irq_enable = control[`CTL_IRQ_EN];
  wire [1:0] rateSel = {control[`CTL_RATE_HI], control[`CTL_RATE_LO]};
  // crystal edge drives every count; a stopped oscillator gives none
  wire xtalTick = xtalSync[1] && !xtalPrev && !osc_stop_ctl;
  // rising strobe only; static levels give no event
  wire strobeRise = strobeSync[1] && !strobePrev;
  // count events per mode; mode 0 stays silent on a zero seed, mode 1 on a zero count
  // so an all-zero write disables the counter instead of wrapping it
  wire slowHit = guard_counter_enable && guardRun && !counter_mode_select &&
    guardSlowTick && (guardSeed != 24'h00_0000);
  wire fastHit = guard_counter_enable && guardRun && counter_mode_select &&
    guardFastTick && (guardCount != 24'h00_0000);
  // Flag set in this cycle; it beats a write-zero clear
  wire reachedSet = (slowHit && (guardCount <= 24'h00_0001)) ||
    (fastHit && (guardCount == 24'h00_0001));

  // next pointer, wrapping past the status register
  function [7:0] nextPtr;
    input [7:0] p;
    begin
      if (p >= `REG_STATUS) begin
        nextPtr = `PTR_FIRST;
      end else begin
        nextPtr = p + 8'h01;
      end
    end
  endfunction

  function isGuard;
    input [7:0] p;
    begin
      isGuard = (p >= `REG_GUARD0) && (p <= `REG_GUARD2);
    end
  endfunction

  // Read mux; time comes from the shadow, guard bytes ascend.
  // A process, not a function, so every register it reads wakes it.
  always @* begin
    if (ptr <= `REG_SEC3) begin
      readNow = secShadow[ptr[1:0]*8 +: 8];
    end else if (isGuard(ptr)) begin
      if (guard_counter_enable) begin
        readNow = guardCount[ptr[1:0]*8 +: 8];
      end else begin
        readNow = guardSeed[ptr[1:0]*8 +: 8];
      end
    end else if (ptr == `REG_CONTROL) begin
      readNow = control;
    end else if (ptr == `REG_STATUS) begin
      readNow = {osc_halted_flag, 6'h00, count_reached_flag};
    end else begin
      readNow = 8'h00;
    end
  end

  tick_divider divider (
    .clock(clock),
    .rstn(rstn),
    .xtalTick(xtalTick),
    .xtalLevel(xtalSync[1]),
    .secClear(secClear),
    .guardClear(guardClear),
    .rate(rateSel),
    .secTick(secTick),
    .guardSlowTick(guardSlowTick),
    .guardFastTick(guardFastTick),
    .waveLevel(waveLevel)
  );

  // Reset release through two flip-flops
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rstMeta <= 1'b0;
      rstn <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstn <= rstMeta;
    end
  end

  // Pin synchronisers; only the second stage feeds edge detection
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      xtalSync <= 2'h0;
      sclSync <= 2'h3;
      sdaSync <= 2'h3;
      strobeSync <= 2'h0;
      xtalPrev <= 1'b0;
      sclPrev <= 1'b1;
      sdaPrev <= 1'b1;
      strobePrev <= 1'b0;
    end else begin
      xtalSync <= {xtalSync[0], xtalIn};
      sclSync <= {sclSync[0], sclIn};
      sdaSync <= {sdaSync[0], sdaIn};
      strobeSync <= {strobeSync[0], guard_strobe_in};
      xtalPrev <= xtalSync[1];
      sclPrev <= sclSync[1];
      sdaPrev <= sdaSync[1];
      strobePrev <= strobeSync[1];
    end
  end

  // Serial slave, register file and counters share one process so that
  // bus writes and count events resolve their priorities in one place.
  // registers get plain reset values; the host must still load them.
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state <= S_IDLE;
      afterAck <= S_IDLE;
      bitCnt <= 4'h0;
      shiftIn <= 8'h00;
      shiftOut <= 8'h00;
      ptr <= `PTR_FIRST;
      nackSeen <= 1'b0;
      sdaOut <= 1'b0;
      sdaOe <= 1'b0;
      seconds_count <= 32'h0000_0000;
      secShadow <= 32'h0000_0000;
      guardCount <= 24'h00_0000;
      guardSeed <= 24'h00_0000;
      guardRun <= 1'b0;
      control <= `CTL_RESET;
      osc_halted_flag <= 1'b1;
      count_reached_flag <= 1'b0;
      pulseActive <= 1'b0;
      pulseCnt <= {`PULSE_WIDTH{1'b0}};
      secClear <= 1'b0;
      guardClear <= 1'b0;
    end else begin
      secClear <= 1'b0;
      guardClear <= 1'b0;
      // seconds advance on each 1 Hz enable
      if (secTick) begin
        seconds_count <= seconds_count + 32'h0000_0001;
      end
      if (busStart || busStop) begin
        secShadow <= seconds_count;
      end
      if (osc_stop_ctl) begin
        osc_halted_flag <= 1'b1;
      end

      // mode 0: once a second, flag and reload at zero
      if (slowHit) begin
        if (guardCount <= 24'h00_0001) begin
          guardCount <= guardSeed;
          count_reached_flag <= 1'b1;
        end else begin
          guardCount <= guardCount - 24'h00_0001;
        end
      end
      // mode 1: 4096 Hz, stop at zero
      if (fastHit) begin
        guardCount <= guardCount - 24'h00_0001;
        if (guardCount == 24'h00_0001) begin
          guardRun <= 1'b0;
          count_reached_flag <= 1'b1;
          if (alarm_irq_enable && output_function_select) begin
            pulseActive <= 1'b1;
            pulseCnt <= {`PULSE_WIDTH{1'b0}};
          end
        end
      end
      // pulse lasts 250 ms of crystal ticks, then the flag clears
      if (pulseActive && xtalTick) begin
        pulseCnt <= pulseCnt + 1'b1;
        if (pulseCnt == `PULSE_TICKS - 1) begin
          pulseActive <= 1'b0;
          count_reached_flag <= 1'b0;
        end
      end
      if (strobeRise && guard_counter_enable && guardSeed != 24'h00_0000) begin
        guardCount <= guardSeed;
        guardRun <= 1'b1;
        guardClear <= 1'b1;
      end

      // Serial bit engine
      if (busStart) begin
        state <= S_ADDR;
        bitCnt <= 4'h0;
        sdaOe <= 1'b0;
      end else if (busStop) begin
        state <= S_IDLE;
        sdaOe <= 1'b0;
      end else begin
        case (state)
          S_ADDR, S_PTR, S_WDATA: begin
            if (sclRise && bitCnt != `BIT_COUNT) begin
              shiftIn <= {shiftIn[6:0], sdaHi};
              bitCnt <= bitCnt + 4'h1;
            end else if (sclFall && bitCnt == `BIT_COUNT) begin
              bitCnt <= 4'h0;
              sdaOe <= 1'b1;
              state <= S_ACK;
              if (state == S_ADDR) begin
                if (shiftIn[7:1] != SLAVE_ADDR) begin
                  sdaOe <= 1'b0;
                  state <= S_IDLE;
                end else if (shiftIn[`READ_BIT]) begin
                  afterAck <= S_RDATA;
                end else begin
                  afterAck <= S_PTR;
                end
              end else if (state == S_PTR) begin
                ptr <= shiftIn;
                afterAck <= S_WDATA;
              end else begin
                afterAck <= S_WDATA;
                ptr <= nextPtr(ptr);
                // capture when the pointer lands on the first location
                if (nextPtr(ptr) == `PTR_FIRST) begin
                  secShadow <= seconds_count;
                end
                if (ptr <= `REG_SEC3) begin
                  seconds_count[ptr[1:0]*8 +: 8] <= shiftIn;
                  secClear <= 1'b1;
                end else if (isGuard(ptr)) begin
                  // write loads counter and seed together
                  guardSeed[ptr[1:0]*8 +: 8] <= shiftIn;
                  guardCount <= guardSeed;
                  guardCount[ptr[1:0]*8 +: 8] <= shiftIn;
                  guardRun <= 1'b1;
                  guardClear <= 1'b1;
                end else if (ptr == `REG_CONTROL) begin
                  control <= shiftIn & `CTL_WMASK;
                end else if (ptr == `REG_STATUS) begin
                  // only a zero clears; set and pulse win
                  if (!shiftIn[`STS_OSC_HALT] && !osc_stop_ctl) begin
                    osc_halted_flag <= 1'b0;
                  end
                  if (!shiftIn[`STS_REACHED] && !pulseActive &&
                      !reachedSet) begin
                    count_reached_flag <= 1'b0;
                  end
                end
              end
            end
          end
          S_ACK: begin
            if (sclFall) begin
              state <= afterAck;
              bitCnt <= 4'h0;
              sdaOe <= 1'b0;
              if (afterAck == S_RDATA) begin
                shiftOut <= {readNow[6:0], 1'b0};
                sdaOe <= !readNow[7];
                bitCnt <= 4'h1;
              end
            end
          end
          S_RDATA: begin
            if (sclFall) begin
              if (bitCnt == `BIT_COUNT) begin
                sdaOe <= 1'b0;
                state <= S_RACK;
                ptr <= nextPtr(ptr);
                if (nextPtr(ptr) == `PTR_FIRST) begin
                  secShadow <= seconds_count;
                end
                // Watchdog mode read reloads the seed
                if (isGuard(ptr) && counter_mode_select &&
                    guard_counter_enable && !strobeSync[1]) begin
                  guardCount <= guardSeed;
                  guardRun <= 1'b1;
                  guardClear <= 1'b1;
                end
              end else begin
                sdaOe <= !shiftOut[7];
                shiftOut <= {shiftOut[6:0], 1'b0};
                bitCnt <= bitCnt + 4'h1;
              end
            end
          end
          S_RACK: begin
            if (sclRise) begin
              nackSeen <= sdaHi;
            end else if (sclFall) begin
              if (nackSeen) begin
                state <= S_IDLE;
              end else begin
                state <= S_RDATA;
                shiftOut <= {readNow[6:0], 1'b0};
                sdaOe <= !readNow[7];
                bitCnt <= 4'h1;
              end
            end
          end
          default: begin
            sdaOe <= 1'b0;
          end
        endcase
      end
    end
  end

  // open drain: data held low, only the enable moves
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wave_or_irq_out <= 1'b0;
      waveOe <= 1'b0;
    end else begin
      wave_or_irq_out <= 1'b0;
      if (!output_function_select) begin
        waveOe <= !osc_stop_ctl && !waveLevel;
      end else if (counter_mode_select) begin
        waveOe <= pulseActive;
      end else begin
        waveOe <= alarm_irq_enable && count_reached_flag;
      end
    end
  end
endmodule

`default_nettype wire

// file: rtl/tick_divider.v
`include "rtc_counter_map.vh"
`default_nettype none

// Up-counting chains from crystal ticks to 4096 Hz and 1 Hz enables
module tick_divider (
  input wire clock,
  input wire rstn,
  input wire xtalTick,
  input wire xtalLevel,
  input wire secClear,
  input wire guardClear,
  input wire [1:0] rate,
  output reg secTick,
  output reg guardSlowTick,
  output reg guardFastTick,
  output reg waveLevel
);
  reg [`PRE_WIDTH-1:0] pre;
  reg [`CHAIN_WIDTH-1:0] secChain;
  reg [`CHAIN_WIDTH-1:0] guardChain;
  wire preWrap = xtalTick && (pre == `PRE_WRAP);

  // Shared prescaler is never cleared, so fast waves survive counter writes
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pre <= {`PRE_WIDTH{1'b0}};
      secChain <= {`CHAIN_WIDTH{1'b0}};
      guardChain <= {`CHAIN_WIDTH{1'b0}};
      secTick <= 1'b0;
      guardSlowTick <= 1'b0;
      guardFastTick <= 1'b0;
      waveLevel <= 1'b0;
    end else begin
      if (xtalTick) begin
        pre <= pre + 1'b1;
      end
      secTick <= preWrap && (secChain == `CHAIN_WRAP) && !secClear;
      guardSlowTick <= preWrap && (guardChain == `CHAIN_WRAP) && !guardClear;
      guardFastTick <= preWrap && !guardClear;
      if (secClear) begin
        secChain <= {`CHAIN_WIDTH{1'b0}};
      end else if (preWrap) begin
        secChain <= secChain + 1'b1;
      end
      if (guardClear) begin
        guardChain <= {`CHAIN_WIDTH{1'b0}};
      end else if (preWrap) begin
        guardChain <= guardChain + 1'b1;
      end
      case (rate)
        `RATE_1HZ: waveLevel <= secChain[`CHAIN_WIDTH-1];
        `RATE_4096HZ: waveLevel <= pre[2];
        `RATE_8192HZ: waveLevel <= pre[1];
        default: waveLevel <= xtalLevel;
      endcase
    end
  end
endmodule

`default_nettype wire

// file: tb/i2c_host.sv
`default_nettype none
module i2c_host (
  input wire logic clock,
  input wire logic sda,
  output var logic scl,
  output var logic sdaLow
);
  timeunit 1ns;
  timeprecision 1ps;
  // Both lines released at power-up; pull-ups hold them high
  initial begin
    scl = 1'b1;
    sdaLow = 1'b0;
  end
  task automatic tick(input int cnt);
    repeat (cnt) @(negedge clock);
  endtask
  // Also a repeated start when entered with the clock low
  task automatic start();
    sdaLow = 1'b0;
    tick(4);
    scl = 1'b1;
    tick(4);
    sdaLow = 1'b1;
    tick(4);
    scl = 1'b0;
    tick(4);
  endtask
  task automatic stop();
    sdaLow = 1'b1;
    tick(4);
    scl = 1'b1;
    tick(4);
    sdaLow = 1'b0;
    tick(8);
  endtask
  // Eight bits then the acknowledge slot, MSB first, 160 ns per bit
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      sdaLow = !tx[i];
      tick(4);
      scl = 1'b1;
      tick(8);
      rx[i] = sda;
      scl = 1'b0;
      tick(4);
    end
  endtask
endmodule
`default_nettype wire

// file: tb/rtc_checker_sva.sv
`default_nettype none
module rtc_checker (
  input wire logic clock,
  input wire logic nrst,
  input wire logic xtalIn,
  input wire logic sclIn,
  input wire logic sdaIn,
  input wire logic sdaOut,
  input wire logic sdaOe,
  input wire logic guard_strobe_in,
  input wire logic wave_or_irq_out,
  input wire logic waveOe
);
  timeunit 1ns;
  timeprecision 1ps;
  // One domain, so clock and disable are stated once
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);

  chk_pin_never_high: assert property (wave_or_irq_out == 1'b0)
    else $error("wave pin data not low");
  chk_sda_never_high: assert property (sdaOut == 1'b0)
    else $error("data pin driven high");
  chk_reset_quiet: assert property ($rose(nrst) |-> !waveOe && !sdaOe)
    else $error("pins pulled right after reset");
  chk_drive_scl_low: assert property ($rose(sdaOe) |-> !sclIn)
    else $error("data pulled while bus clock high");
  chk_scl_high_hold: assert property (
    sclIn && $past(sclIn) |-> $stable(sdaOe))
    else $error("data moved while bus clock high");
  chk_ack_hold_min: assert property ($rose(sdaOe) |=> sdaOe [*4])
    else $error("drive dropped too soon");
  chk_start_quiet: assert property (
    sclIn && $fell(sdaIn) |-> (!sdaOe) [*8])
    else $error("drive after start");
  chk_stop_quiet: assert property (
    sclIn && $rose(sdaIn) |-> (!sdaOe) [*8])
    else $error("drive after stop");

  cov_wave_low: cover property ($rose(waveOe));
  cov_ack: cover property ($rose(sdaOe));
  cov_start: cover property (sclIn && $fell(sdaIn));
endmodule

bind seconds_counter_rtc rtc_checker i_chk (
  .clock(clock), .nrst(nrst), .xtalIn(xtalIn), .sclIn(sclIn),
  .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
  .guard_strobe_in(guard_strobe_in), .wave_or_irq_out(wave_or_irq_out),
  .waveOe(waveOe));
`default_nettype wire

// file: tb/tb.sv
`include "rtc_counter_map.vh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [6:0] DEV = 7'h5A; // Arbitrary, as the device default
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic xtalIn = 1'b0;
  logic guard_strobe_in = 1'b0;
  logic scl, hostLow, sdaOut, sdaOe, waveOut, waveOe, seen;
  logic [8:0] rx;
  logic [31:0] seed = 32'h5C9DF52B;
  logic [7:0] mdl [0:8];
  logic [7:0] bytes [$];
  int hz [4] = '{1, 4096, 8192, 32768};
  int fails = 0;
  int compares = 0;
  int cycles = 0;
  int n;
  time t0;
  wire sdaWire;
  // Open-drain data line with pull-up
  assign sdaWire = !(hostLow | sdaOe);
  always #5 clock = ~clock;
  // Sped-up timebase, 4 clocks per period
  always begin
    repeat (2) @(negedge clock);
    xtalIn = ~xtalIn;
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 60000) begin
      fails++;
      report_and_stop();
    end
  end
  seconds_counter_rtc i_dut (.clock(clock), .nrst(nrst), .xtalIn(xtalIn),
    .sclIn(scl), .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .guard_strobe_in(guard_strobe_in), .wave_or_irq_out(waveOut),
    .waveOe(waveOe));
  i2c_host i_host (.clock(clock), .sda(sdaWire), .scl(scl),
    .sdaLow(hostLow));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chkByte(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chkVal(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic addr(input logic [7:0] ptr);
    i_host.start();
    i_host.xfer({DEV, 1'b0, 1'b1}, rx);
    chkVal(rx[0], 1'b0);
    chkVal(sdaOut, 1'b0);
    i_host.xfer({ptr, 1'b1}, rx);
  endtask
  task automatic wr(input logic [7:0] ptr);
    addr(ptr);
    foreach (bytes[i]) begin
      i_host.xfer({bytes[i], 1'b1}, rx);
      if (ptr == `REG_CONTROL) mdl[ptr] = bytes[i] & `CTL_WMASK;
      else if (ptr == `REG_STATUS) mdl[ptr] = mdl[ptr] & bytes[i];
      else mdl[ptr] = bytes[i];
      ptr = (ptr == `REG_STATUS) ? `PTR_FIRST : ptr + 8'h01;
    end
    i_host.stop();
  endtask
  task automatic rd(input logic [7:0] ptr, input int cnt);
    addr(ptr);
    i_host.start();
    i_host.xfer({DEV, 1'b1, 1'b1}, rx);
    for (int i = 0; i < cnt; i++) begin
      i_host.xfer({8'hFF, i == cnt - 1}, rx);
      chkByte(rx[8:1], mdl[ptr]);
      ptr = (ptr == `REG_STATUS) ? `PTR_FIRST : ptr + 8'h01;
    end
    i_host.stop();
  endtask
  // Counts clocks until the wave pin enable newly reaches lvl
  task automatic waitLevel(input logic lvl, input int lim);
    logic p;
    n = 0;
    do begin
      p = waveOe;
      @(negedge clock);
      n++;
    end while (!(waveOe === lvl && p !== lvl) && n < lim);
  endtask
  task automatic report_and_stop();
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (3) @(negedge clock);
    nrst = 1'b1;
    repeat (8) @(negedge clock);
    mdl[`REG_CONTROL] = `CTL_RESET;
    mdl[`REG_STATUS] = 8'h80;
    rd(`REG_CONTROL, 2);
    i_host.start();
    i_host.xfer({DEV ^ 7'h01, 1'b0, 1'b1}, rx);
    chkVal(rx[0], 1'b1);
    i_host.stop();
    $display("test reset done");
    // random bytes, then wrap past status into byte 0
    for (int i = 0; i < 7; i++) begin
      seed = lfsr(seed);
      bytes.push_back(seed[7:0]);
    end
    bytes.push_back(`CTL_RESET);
    bytes.push_back(8'h00);
    bytes.push_back(8'hA5);
    wr(`REG_SEC0);
    rd(`REG_SEC0, 9);
    rd(`REG_STATUS, 3);
    $display("test map done");
    // fast watchdog mode, pulse output enabled
    bytes = {8'h69};
    wr(`REG_CONTROL);
    bytes = {8'h28, 8'h00, 8'h00};
    wr(`REG_GUARD0);
    seen = 1'b0;
    repeat (4) begin
      repeat (600) begin
        @(negedge clock);
        seen = seen | waveOe;
      end
      // Held high long enough that a restart on the level or on the
      // falling edge would move the timeout measured below
      guard_strobe_in = 1'b1;
      repeat (300) @(negedge clock);
      guard_strobe_in = 1'b0;
    end
    chkVal(seen, 1'b0);
    waitLevel(1'b1, 3000);
    chkVal(n inside {[945:1025]}, 1'b1);
    t0 = $time;
    mdl[`REG_STATUS] = 8'h01;
    rd(`REG_STATUS, 1);
    bytes = {8'h00};
    wr(`REG_STATUS);
    mdl[`REG_STATUS] = 8'h01;
    rd(`REG_STATUS, 1);
    waitLevel(1'b0, 40000);
    chkVal((($time - t0) / 10) inside {[32760:32780]}, 1'b1);
    mdl[`REG_STATUS] = 8'h00;
    rd(`REG_STATUS, 1);
    $display("test watchdog done");
    // square wave; the 1 Hz code would outlast the run
    for (int r = 1; r < 4; r++) begin
      bytes = {8'(r * 2)};
      wr(`REG_CONTROL);
      waitLevel(1'b1, 200);
      waitLevel(1'b1, 200);
      chkVal(n, 4 * 32768 / hz[r]);
      chkVal(waveOut, 1'b0);
    end
    $display("test wave done");
    report_and_stop();
  end
endmodule
`default_nettype wire
